//--- src/switch_intx_msi_aggregator.v
// Behaviour
// - Address-routed TLPs go by address window; 64-bit headers match a window only with the upper 32 address bits zero.
// - Config, completions and ID messages go by bus number of the target ID.
// - Messages support route-to-root, broadcast-from-root and local termination.
// - Gathered-to-root only for PME_TO_Ack arriving on a downstream port.
// - Unmasked condition asserting with MSI enabled emits an MSI.
// - With MSI off, assertion raises INTA unless legacy interrupts are disabled.
// - Negation drops INTA only with MSI off and legacy interrupts enabled.
// - Condition ends when every causing unmasked status bit is masked or cleared.
// - An MSI from a live port (link up and in the partition) is forwarded to the upstream port; a second one while the first is still pending merges with it.
// - Sources are hot-plug and two bandwidth bits, the latter when enabled.
// - A port's own legacy interrupt uses only wire A.
// - Keep aggregated state for wires A to D at the upstream port only.
// - Send Assert_INTx when the upstream aggregate rises.
// - Send Deassert_INTx when the upstream aggregate falls.
// - Downstream bridges do no remapping; remap only at upstream.
// - Upstream rotates device N wire y to wire (y + N mod 4) mod 4.
// - Device wires include received and self-generated interrupts.
// - Link down or leaving the partition negates that port's wires.
// - Each partition is an independent instance with separate state.
`timescale 1ns/100ps
`include "intx_agg_map.vh"
module switch_intx_msi_aggregator (
   input  wire                clk,
   input  wire                arst_n,
   input  wire [`ADDR_W-1:0]  reg_addr,
   input  wire [31:0]         reg_wdata,
   input  wire                reg_wr,
   input  wire                reg_rd,
   output reg  [31:0]         reg_rdata_q,
   input  wire [3:0]          hp_event,
   input  wire [3:0]          bwm_event,
   input  wire [3:0]          abw_event,
   input  wire [3:0]          link_up,
   input  wire [15:0]         ext_intx,
   input  wire [3:0]          up_own_intx,
   output reg                 intx_msg_valid_q,
   output reg                 intx_msg_assert_q,
   output reg  [1:0]          intx_msg_wire_q,
   output reg                 msi_valid_q,
   output reg  [1:0]          msi_src_port_q,
   output reg  [63:0]         msi_addr_q,
   input  wire                tlp_valid,
   input  wire [6:0]          tlp_fmt_type,
   input  wire [63:0]         tlp_addr,
   input  wire [15:0]         tlp_dest_id,
   input  wire [7:0]          tlp_msg_code,
   input  wire                tlp_src_up,
   output wire                route_valid_q,
   output wire [4:0]          route_port_q,
   output wire [2:0]          route_method_q,
   output wire                route_drop_q
);
   // One instance serves one partition; no state is shared between instances.

   ////////////////////////////////////////////////////////////////////////////////
   // Register decode

   reg  [31:0] pctrl_q   [0:3];
   reg  [2:0]  pstat_q   [0:3];
   reg  [31:0] msi_lo_q  [0:3];
   reg  [31:0] msi_hi_q  [0:3];
   reg  [31:0] win_mem_q [0:3];
   reg  [15:0] win_bus_q [0:3];
   reg  [7:0]  own_bus_q;
   reg  [3:0]  agg_q;
   reg  [3:0]  sent_q;
   reg  [3:0]  msi_pend_q;
   reg  [31:0] rdata_d;

   wire        in_port = (reg_addr >= `OFF_PORT_BASE) && (reg_addr < `OFF_WIN_BASE);
   wire        in_win  = (reg_addr >= `OFF_WIN_BASE) && (reg_addr < (`OFF_WIN_BASE + 8'h40));
   wire [7:0]  prel    = reg_addr - `OFF_PORT_BASE;
   wire [7:0]  wrel    = reg_addr - `OFF_WIN_BASE;
   wire [1:0]  psel    = prel[5:4];
   wire [1:0]  wsel    = wrel[5:4];
   wire [3:0]  pofs    = prel[3:0];
   wire [3:0]  wofs    = wrel[3:0];

   ////////////////////////////////////////////////////////////////////////////////
   // Per port interrupt generation

   wire [3:0]  msi_pulse;
   wire [3:0]  own_inta;
   wire [3:0]  port_live;
   wire [127:0] win_mem_flat;
   wire [63:0] win_bus_flat;

   genvar g;
   generate
      for (g = 0; g < `NUM_DS; g = g + 1) begin : g_port
         wire [2:0] unmask = {pctrl_q[g][`PC_ABW_IE], pctrl_q[g][`PC_BWM_IE],
                              ~pctrl_q[g][`PC_HP_MASK]};
         port_irq_gen u_gen (
            .clk                (clk),
            .arst_n             (arst_n),
            .status             (pstat_q[g]),
            .unmask             (unmask),
            .msi_en             (pctrl_q[g][`PC_MSI_EN]),
            .legacy_irq_disable (pctrl_q[g][`PC_LEG_DIS]),
            .msi_pulse_q        (msi_pulse[g]),
            .inta_q             (own_inta[g])
         );
         assign port_live[g] = link_up[g] & pctrl_q[g][`PC_IN_PART];
         assign win_mem_flat[32*g +: 32]   = win_mem_q[g];
         assign win_bus_flat[16*g +: 16]   = win_bus_q[g];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Register writes and hardware status

   integer p;
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         for (p = 0; p < `NUM_DS; p = p + 1) begin
            pctrl_q[p]   <= `PCTRL_RST;
            pstat_q[p]   <= 3'h0;
            msi_lo_q[p]  <= 32'h0000_0000;
            msi_hi_q[p]  <= 32'h0000_0000;
            win_mem_q[p] <= 32'h0000_0000;
            win_bus_q[p] <= 16'h0000;
         end
         own_bus_q <= 8'h00;
      end else begin
         for (p = 0; p < `NUM_DS; p = p + 1) begin
            // Hardware set wins over a write-one-to-clear in the same cycle
            pstat_q[p] <= (pstat_q[p] & ~((reg_wr && in_port && psel == p[1:0] && pofs == `OFF_PSTAT)
                                          ? reg_wdata[2:0] : 3'h0))
                          | {abw_event[p], bwm_event[p], hp_event[p]};
         end
         if (reg_wr && in_port) begin
            case (pofs)
               `OFF_PCTRL:  pctrl_q[psel]  <= reg_wdata & 32'h0000_1F3F;
               `OFF_MSI_LO: msi_lo_q[psel] <= {reg_wdata[31:2], 2'b00};
               `OFF_MSI_HI: msi_hi_q[psel] <= reg_wdata;
               default:     ;
            endcase
         end
         if (reg_wr && in_win) begin
            case (wofs)
               `OFF_WIN_MEM: win_mem_q[wsel] <= reg_wdata;
               `OFF_WIN_BUS: win_bus_q[wsel] <= reg_wdata[15:0];
               default:      ;
            endcase
         end
         if (reg_wr && reg_addr == `OFF_ROUTE_BUS) begin
            own_bus_q <= reg_wdata[7:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Register reads, data one cycle after the strobe

   always @* begin
      rdata_d = 32'h0000_0000;
      if (reg_addr == `OFF_AGG_STATE) begin
         rdata_d = {24'h0, sent_q, agg_q};
      end else if (reg_addr == `OFF_ROUTE_BUS) begin
         rdata_d = {24'h0, own_bus_q};
      end else if (in_port) begin
         case (pofs)
            `OFF_PCTRL:  rdata_d = pctrl_q[psel];
            `OFF_PSTAT:  rdata_d = {22'h0, port_live[psel], own_inta[psel], 5'h0, pstat_q[psel]};
            `OFF_MSI_LO: rdata_d = msi_lo_q[psel];
            `OFF_MSI_HI: rdata_d = msi_hi_q[psel];
            default:     rdata_d = 32'h0000_0000;
         endcase
      end else if (in_win) begin
         case (wofs)
            `OFF_WIN_MEM: rdata_d = win_mem_q[wsel];
            `OFF_WIN_BUS: rdata_d = {16'h0, win_bus_q[wsel]};
            default:      rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata_q <= 32'h0000_0000;
      end else begin
         reg_rdata_q <= reg_rd ? rdata_d : 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Legacy wire aggregation at the upstream port

   reg [3:0] dev_wires [0:3];
   reg [3:0] agg_d;
   reg [1:0] rot;
   integer   q;
   integer   y;

   always @* begin
      agg_d = up_own_intx;
      for (q = 0; q < `NUM_DS; q = q + 1) begin
         // Own interrupt only on wire A; downstream bridges pass wires unmapped.
         dev_wires[q] = (ext_intx[4*q +: 4] | {3'b000, own_inta[q]})
                        & {4{port_live[q]}};
         rot = pctrl_q[q][`PC_DEV_LO +: 2];
         for (y = 0; y < 4; y = y + 1) begin
            agg_d[(y + rot) % 4] = agg_d[(y + rot) % 4] | dev_wires[q][y];
         end
      end
   end

   // Each wire differing from what the root last heard is reported, lowest first.
   reg [1:0] pick;
   reg       pick_ok;
   integer   k;
   always @* begin
      pick    = 2'b00;
      pick_ok = 1'b0;
      for (k = 3; k >= 0; k = k - 1) begin
         if (agg_q[k] != sent_q[k]) begin
            pick    = k[1:0];
            pick_ok = 1'b1;
         end
      end
   end

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         agg_q             <= 4'h0;
         sent_q            <= 4'h0;
         intx_msg_valid_q  <= 1'b0;
         intx_msg_assert_q <= 1'b0;
         intx_msg_wire_q   <= 2'b00;
      end else begin
         agg_q            <= agg_d;
         intx_msg_valid_q <= pick_ok;
         if (pick_ok) begin
            sent_q[pick]      <= agg_q[pick];
            intx_msg_assert_q <= agg_q[pick];
            intx_msg_wire_q   <= pick;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // MSI forwarding to the upstream port

   reg [1:0] msel;
   reg       msel_ok;
   integer   m;
   always @* begin
      msel    = 2'b00;
      msel_ok = 1'b0;
      for (m = 3; m >= 0; m = m - 1) begin
         if (msi_pend_q[m]) begin
            msel    = m[1:0];
            msel_ok = 1'b1;
         end
      end
   end

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         msi_pend_q     <= 4'h0;
         msi_valid_q    <= 1'b0;
         msi_src_port_q <= 2'b00;
         msi_addr_q     <= 64'h0000_0000_0000_0000;
      end else begin
         msi_pend_q  <= (msi_pend_q & ~({3'b000, msel_ok} << msel)) | (msi_pulse & port_live);
         msi_valid_q <= msel_ok;
         if (msel_ok) begin
            msi_src_port_q <= msel;
            msi_addr_q     <= {msi_hi_q[msel], msi_lo_q[msel]};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Transaction routing selection

   route_select u_route (
      .clk            (clk),
      .arst_n         (arst_n),
      .tlp_valid      (tlp_valid),
      .tlp_fmt_type   (tlp_fmt_type),
      .tlp_addr       (tlp_addr),
      .tlp_dest_id    (tlp_dest_id),
      .tlp_msg_code   (tlp_msg_code),
      .tlp_src_up     (tlp_src_up),
      .win_mem        (win_mem_flat),
      .win_bus        (win_bus_flat),
      .port_live      (port_live),
      .route_valid_q  (route_valid_q),
      .route_port_q   (route_port_q),
      .route_method_q (route_method_q),
      .route_drop_q   (route_drop_q)
   );
endmodule // switch_intx_msi_aggregator

//--- src/intx_agg_map.vh
`ifndef INTX_AGG_MAP_VH
`define INTX_AGG_MAP_VH
`define NUM_DS            4
`define ADDR_W            8
// Global registers
`define OFF_AGG_STATE     8'h00
`define OFF_ROUTE_BUS     8'h04
// Per downstream port block p sits at OFF_PORT_BASE + p*PORT_STRIDE
`define OFF_PORT_BASE     8'h10
`define PORT_STRIDE       8'h10
`define OFF_PCTRL         4'h0
`define OFF_PSTAT         4'h4
`define OFF_MSI_LO        4'h8
`define OFF_MSI_HI        4'hC
// Per port routing windows at OFF_WIN_BASE + p*WIN_STRIDE
`define OFF_WIN_BASE      8'h50
`define WIN_STRIDE        8'h10
`define OFF_WIN_MEM       4'h0
`define OFF_WIN_BUS       4'h4
// Port control fields
`define PC_MSI_EN         0
`define PC_LEG_DIS        1
`define PC_BWM_IE         2
`define PC_ABW_IE         3
`define PC_HP_MASK        4
`define PC_IN_PART        5
`define PC_DEV_LO         8
`define PC_DEV_HI         12
`define PCTRL_RST         32'h0000_0020
// Port status fields, PS_HP to PS_ABW write one to clear, PS_INTA and PS_LINK_UP read only
`define PS_HP             0
`define PS_BWM            1
`define PS_ABW            2
`define PS_INTA           8
`define PS_LINK_UP        9
// Routing methods
`define RT_ADDR           3'h0
`define RT_ID             3'h1
`define RT_ROOT           3'h2
`define RT_BCAST          3'h3
`define RT_LOCAL          3'h4
`define RT_GATHER         3'h5
`define RT_NONE           3'h7
`define MSG_PME_TO_ACK    8'h1B
`endif

//--- src/port_irq_gen.v
`timescale 1ns/100ps
module port_irq_gen (
   input  wire       clk,
   input  wire       arst_n,
   input  wire [2:0] status,
   input  wire [2:0] unmask,
   input  wire       msi_en,
   input  wire       legacy_irq_disable,
   output reg        msi_pulse_q,
   output reg        inta_q
);
   reg  cond_q;
   wire cond_d = |(status & unmask);

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cond_q      <= 1'b0;
         msi_pulse_q <= 1'b0;
         inta_q      <= 1'b0;
      end else begin
         cond_q      <= cond_d;
         msi_pulse_q <= cond_d & ~cond_q & msi_en;
         if (cond_d && !cond_q && !msi_en && !legacy_irq_disable) begin
            inta_q <= 1'b1;
         end else if (!cond_d && cond_q && !msi_en && !legacy_irq_disable) begin
            inta_q <= 1'b0;
         end
      end
   end
endmodule // port_irq_gen

//--- src/route_select.v
`timescale 1ns/100ps
`include "intx_agg_map.vh"
module route_select (
   input  wire        clk,
   input  wire        arst_n,
   input  wire        tlp_valid,
   input  wire [6:0]  tlp_fmt_type,
   input  wire [63:0] tlp_addr,
   input  wire [15:0] tlp_dest_id,
   input  wire [7:0]  tlp_msg_code,
   input  wire        tlp_src_up,
   input  wire [127:0] win_mem,
   input  wire [63:0] win_bus,
   input  wire [3:0]  port_live,
   output reg         route_valid_q,
   output reg  [4:0]  route_port_q,
   output reg  [2:0]  route_method_q,
   output reg         route_drop_q
);
   reg [4:0] port_d;
   reg [2:0] meth_d;
   reg       drop_d;
   reg [3:0] amatch;
   reg [3:0] imatch;
   integer   i;
   wire [4:0] ty    = tlp_fmt_type[4:0];
   wire       is4dw = tlp_fmt_type[5];
   wire       is_msg = (ty[4:3] == 2'b10);
   wire       by_addr = (ty[4:1] == 4'b0000) || (ty == 5'b00010) || (is_msg && ty[2:0] == 3'b001);
   wire       by_id   = (ty[4:1] == 4'b0010) || (ty[4:1] == 4'b0101) || (is_msg && ty[2:0] == 3'b010);

   always @* begin
      for (i = 0; i < `NUM_DS; i = i + 1) begin
         amatch[i] = port_live[i] && (!is4dw || tlp_addr[63:32] == 32'h0000_0000) &&
                     tlp_addr[31:16] >= win_mem[32*i +: 16] && tlp_addr[31:16] <= win_mem[32*i+16 +: 16];
         imatch[i] = port_live[i] && tlp_dest_id[15:8] >= win_bus[16*i +: 8] &&
                     tlp_dest_id[15:8] <= win_bus[16*i+8 +: 8];
      end
      port_d = 5'h00;
      meth_d = `RT_NONE;
      drop_d = 1'b0;
      if (by_addr) begin
         meth_d = `RT_ADDR;
         port_d = (|amatch) ? {amatch, 1'b0} : {4'h0, ~tlp_src_up};
      end else if (by_id) begin
         meth_d = `RT_ID;
         port_d = (|imatch) ? {imatch, 1'b0} : {4'h0, ~tlp_src_up};
      end else if (is_msg && ty[2:0] == 3'b000) begin
         meth_d = `RT_ROOT;
         port_d = {4'h0, ~tlp_src_up};
      end else if (is_msg && ty[2:0] == 3'b011) begin
         meth_d = `RT_BCAST;
         port_d = tlp_src_up ? {port_live, 1'b0} : 5'h00;
      end else if (is_msg && ty[2:0] == 3'b100) begin
         meth_d = `RT_LOCAL;
      end else if (is_msg && ty[2:0] == 3'b101 && !tlp_src_up && tlp_msg_code == `MSG_PME_TO_ACK) begin
         meth_d = `RT_GATHER;
         port_d = 5'h01;
      end
      if (meth_d != `RT_LOCAL && port_d == 5'h00) begin
         drop_d = 1'b1;
      end
   end

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         route_valid_q  <= 1'b0;
         route_port_q   <= 5'h00;
         route_method_q <= `RT_NONE;
         route_drop_q   <= 1'b0;
      end else begin
         route_valid_q  <= tlp_valid;
         route_port_q   <= tlp_valid ? port_d : 5'h00;
         route_method_q <= tlp_valid ? meth_d : `RT_NONE;
         route_drop_q   <= tlp_valid & drop_d;
      end
   end
endmodule // route_select

//--- dv/intx_agg_props.sv
`timescale 1ns/100ps
`include "intx_agg_map.vh"
module intx_agg_props (
   input wire        clk,
   input wire        arst_n,
   input wire [3:0]  link_up,
   input wire [3:0]  up_own_intx,
   input wire        intx_msg_valid_q,
   input wire        intx_msg_assert_q,
   input wire [1:0]  intx_msg_wire_q,
   input wire        msi_valid_q,
   input wire [63:0] msi_addr_q,
   input wire        tlp_valid,
   input wire [7:0]  tlp_msg_code,
   input wire        tlp_src_up,
   input wire        route_valid_q,
   input wire [4:0]  route_port_q,
   input wire [2:0]  route_method_q,
   input wire        route_drop_q
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   ////////////////////////////////////////////////////////////////
   // Wire levels as the root has been told them
   reg [3:0] sent_q;
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) sent_q <= 4'h0;
      else if (intx_msg_valid_q) sent_q[intx_msg_wire_q] <= intx_msg_assert_q;
   end
   sequence tlp_taken;
      tlp_valid;
   endsequence
   sequence route_given;
      route_valid_q || route_drop_q;
   endsequence
   ////////////////////////////////////////////////////////////////
   assert_edge_a: assert property (intx_msg_valid_q && intx_msg_assert_q |-> !sent_q[intx_msg_wire_q])
      else $error("assert message on a wire already asserted");
   deassert_edge_a: assert property (intx_msg_valid_q && !intx_msg_assert_q |-> sent_q[intx_msg_wire_q])
      else $error("deassert message on a wire not asserted");
   link_quiet_a: assert property ((link_up == 4'h0 && up_own_intx == 4'h0) [*4] |-> !(intx_msg_valid_q && intx_msg_assert_q))
      else $error("assert message while every port is down");
   route_answer_a: assert property (tlp_taken |=> route_given)
      else $error("routing answer missing");
   route_cause_a: assert property (route_given |-> $past(tlp_valid))
      else $error("routing answer without request");
   one_port_a: assert property (route_valid_q && !route_drop_q && route_method_q != `RT_BCAST && route_method_q != `RT_LOCAL |-> $onehot(route_port_q))
      else $error("directed route not to exactly one port");
   root_port_a: assert property (route_valid_q && route_method_q == `RT_ROOT |-> route_port_q == 5'h01)
      else $error("route to root not upstream");
   gather_ack_a: assert property (route_valid_q && route_method_q == `RT_GATHER |-> $past(tlp_msg_code) == `MSG_PME_TO_ACK && !$past(tlp_src_up))
      else $error("gathered route for a wrong message");
   msi_aligned_a: assert property (msi_valid_q |-> msi_addr_q[1:0] == 2'h0)
      else $error("forwarded msi address not aligned");
endmodule // intx_agg_props
bind switch_intx_msi_aggregator intx_agg_props u_props (.*);

//--- dv/root_ep_model.sv
`timescale 1ns/100ps
module root_ep_model (
   input  wire        clk,
   input  wire        arst_n,
   input  wire [15:0] ep_wires,
   input  wire        intx_msg_valid_q,
   input  wire        intx_msg_assert_q,
   input  wire [1:0]  intx_msg_wire_q,
   input  wire        msi_valid_q,
   output wire [15:0] ext_intx,
   output reg  [3:0]  root_wires_q,
   output reg  [7:0]  msi_count_q
);
   // Endpoint levels stand even over a dead link
   assign ext_intx = ep_wires;
   // Root keeps one level per virtual wire
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         root_wires_q <= 4'h0;
         msi_count_q  <= 8'h00;
      end else begin
         if (intx_msg_valid_q) root_wires_q[intx_msg_wire_q] <= intx_msg_assert_q;
         if (msi_valid_q) msi_count_q <= msi_count_q + 8'h01;
      end
   end
endmodule // root_ep_model

//--- dv/tb.sv
`timescale 1ns/100ps
`include "intx_agg_map.vh"
module tb;
   logic        clk = 1'b0;
   logic        arst_n = 1'b0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic [3:0]  hp_event = 4'h0, bwm_event = 4'h0, abw_event = 4'h0, link_up = 4'h0, up_own_intx = 4'h0;
   logic [15:0] ep_wires = 16'h0;
   logic        tlp_valid = 1'b0;
   logic [6:0]  tlp_fmt_type = 7'h0;
   logic [63:0] tlp_addr = 64'h0;
   logic [15:0] tlp_dest_id = 16'h0;
   logic [7:0]  tlp_msg_code = 8'h0;
   logic        tlp_src_up = 1'b0;
   logic [31:0] reg_rdata_q;
   logic [15:0] ext_intx;
   logic        intx_msg_valid_q, intx_msg_assert_q, msi_valid_q, route_valid_q, route_drop_q;
   logic [1:0]  intx_msg_wire_q, msi_src_port_q;
   logic [63:0] msi_addr_q;
   logic [4:0]  route_port_q;
   logic [2:0]  route_method_q;
   logic [3:0]  root_wires_q;
   logic [7:0]  msi_count_q;
   int          errors = 0;
   int          n_compared = 0;
   initial forever #4 clk = ~clk;
   switch_intx_msi_aggregator dut (.*);
   root_ep_model far_end (.*);
   ////////////////////////////////////////////////////////////////
   task automatic results();
      $display("Counts: %0d compared, %0d mismatched", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic fail(input string s);
      errors++;
      $display("BAD %0t %s", $time, s);
      results();
   endtask
   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t got %0h expected %0h", $time, got, exp);
      end
   endtask
   function automatic logic [7:0] pa(input int p, input logic [7:0] off);
      return 8'(`OFF_PORT_BASE + p * `PORT_STRIDE + off);
   endfunction
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata_q;
   endtask
   task automatic setw(input logic [15:0] ep, input logic [3:0] own);
      @(posedge clk);
      ep_wires <= ep;
      up_own_intx <= own;
      #1;
   endtask
   task automatic ev(input logic [3:0] hp, input logic [3:0] bw, input logic [3:0] abw);
      @(posedge clk);
      hp_event <= hp;
      bwm_event <= bw;
      abw_event <= abw;
      @(posedge clk);
      {hp_event, bwm_event, abw_event} <= 12'h000;
      #1;
   endtask
   task automatic wait_msg(input logic a, input logic [1:0] w);
      int i;
      for (i = 0; i < 12 && intx_msg_valid_q !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      if (i == 12) fail("no interrupt message");
      check({intx_msg_assert_q, intx_msg_wire_q}, {a, w});
      @(posedge clk);
      #1;
   endtask
   task automatic quiet(input int n);
      logic seen;
      seen = 1'b0;
      repeat (n) begin
         @(posedge clk);
         #1 seen = seen | intx_msg_valid_q;
      end
      check(seen, 1'b0);
   endtask
   task automatic wait_msi(input logic [1:0] p, input logic [63:0] a);
      int i;
      for (i = 0; i < 12 && msi_valid_q !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      if (i == 12) fail("no msi");
      check(msi_src_port_q, p);
      check(msi_addr_q, a);
   endtask
   task automatic send(input logic [6:0] ft, input logic [63:0] ad, input logic [15:0] id, input logic [7:0] code,
                       input logic up, input logic [4:0] port, input logic [2:0] meth, input logic drop);
      @(posedge clk);
      tlp_valid <= 1'b1;
      tlp_fmt_type <= ft;
      tlp_addr <= ad;
      tlp_dest_id <= id;
      tlp_msg_code <= code;
      tlp_src_up <= up;
      @(posedge clk);
      tlp_valid <= 1'b0;
      #1 check(route_drop_q, drop);
      if (!drop) check({route_valid_q, route_method_q}, {1'b1, meth});
      if (!drop && port !== 5'h00) check(route_port_q, port);
   endtask
   ////////////////////////////////////////////////////////////////
   task automatic t_regs();
      logic [31:0] d;
      rd(pa(0, `OFF_PCTRL), d);
      check(d, `PCTRL_RST);
      rd(`OFF_AGG_STATE, d);
      check(d, 32'h0);
      rd(8'hF0, d);
      check(d, 32'h0);
      $display("test regs done");
   endtask
   task automatic t_rotate();
      int n;
      for (n = 0; n < 4; n++) begin
         wr(pa(1, `OFF_PCTRL), 32'h20 | (n << 8));
         setw(16'h0010, 4'h0);
         wait_msg(1'b1, 2'(n));
         setw(16'h0000, 4'h0);
         wait_msg(1'b0, 2'(n));
      end
      setw(16'h0040, 4'h0);
      wait_msg(1'b1, 2'h1);
      setw(16'h0002, 4'h0);
      quiet(6);
      setw(16'h0000, 4'h0);
      wait_msg(1'b0, 2'h1);
      $display("test rotate done");
   endtask
   task automatic t_or();
      wr(pa(1, `OFF_PCTRL), 32'h20);
      setw(16'h0001, 4'h0);
      wait_msg(1'b1, 2'h0);
      setw(16'h0011, 4'h0);
      quiet(6);
      setw(16'h0010, 4'h0);
      quiet(6);
      setw(16'h0000, 4'h8);
      wait_msg(1'b0, 2'h0);
      wait_msg(1'b1, 2'h3);
      setw(16'h0000, 4'h0);
      wait_msg(1'b0, 2'h3);
      $display("test aggregate done");
   endtask
   task automatic t_own();
      logic [31:0] d;
      logic [7:0]  c;
      wr(pa(2, `OFF_PCTRL), 32'h120);
      ev(4'h4, 4'h0, 4'h0);
      wait_msg(1'b1, 2'h1);
      rd(pa(2, `OFF_PSTAT), d);
      check(d[8], 1'b1);
      wr(pa(2, `OFF_PSTAT), 32'h1);
      wait_msg(1'b0, 2'h1);
      ev(4'h4, 4'h0, 4'h0);
      wait_msg(1'b1, 2'h1);
      wr(pa(2, `OFF_PCTRL), 32'h130);
      wait_msg(1'b0, 2'h1);
      wr(pa(2, `OFF_PSTAT), 32'h1);
      wr(pa(2, `OFF_PCTRL), 32'h122);
      ev(4'h4, 4'h0, 4'h0);
      quiet(8);
      wr(pa(2, `OFF_PSTAT), 32'h1);
      quiet(6);
      wr(pa(2, `OFF_MSI_LO), 32'hFEE0_1000);
      wr(pa(2, `OFF_MSI_HI), 32'h0000_0001);
      wr(pa(2, `OFF_PCTRL), 32'h123);
      ev(4'h4, 4'h0, 4'h0);
      wait_msi(2'h2, 64'h0000_0001_FEE0_1000);
      wr(pa(2, `OFF_PSTAT), 32'h1);
      quiet(6);
      wr(pa(2, `OFF_PCTRL), 32'h125);
      c = msi_count_q;
      ev(4'h0, 4'h0, 4'h4);
      quiet(8);
      check(msi_count_q, c);
      ev(4'h0, 4'h4, 4'h0);
      wait_msi(2'h2, 64'h0000_0001_FEE0_1000);
      wr(pa(2, `OFF_PSTAT), 32'h6);
      $display("test port interrupts done");
   endtask
   task automatic t_link();
      setw(16'h0001, 4'h0);
      wait_msg(1'b1, 2'h0);
      @(posedge clk);
      link_up <= 4'hE;
      wait_msg(1'b0, 2'h0);
      @(posedge clk);
      link_up <= 4'hF;
      wait_msg(1'b1, 2'h0);
      wr(pa(0, `OFF_PCTRL), 32'h0);
      wait_msg(1'b0, 2'h0);
      wr(pa(0, `OFF_PCTRL), 32'h20);
      wait_msg(1'b1, 2'h0);
      setw(16'h0000, 4'h0);
      wait_msg(1'b0, 2'h0);
      check(root_wires_q, 4'h0);
      $display("test link done");
   endtask
   task automatic t_route();
      wr(8'h50, 32'h1FFF_1000);
      wr(8'h54, 32'h0000_0505);
      wr(8'h60, 32'h2FFF_2000);
      wr(8'h64, 32'h0000_0606);
      send(7'h00, 64'h1234_0000, 16'h0, 8'h0, 1'b1, 5'h02, `RT_ADDR, 1'b0);
      send(7'h60, 64'h2345_0000, 16'h0, 8'h0, 1'b1, 5'h04, `RT_ADDR, 1'b0);
      send(7'h60, 64'h1_1234_0000, 16'h0, 8'h0, 1'b1, 5'h00, `RT_ADDR, 1'b1);
      send(7'h00, 64'h9000_0000, 16'h0, 8'h0, 1'b1, 5'h00, `RT_ADDR, 1'b1);
      send(7'h04, 64'h0, 16'h0600, 8'h0, 1'b1, 5'h04, `RT_ID, 1'b0);
      send(7'h0A, 64'h0, 16'h0500, 8'h0, 1'b1, 5'h02, `RT_ID, 1'b0);
      send(7'h30, 64'h0, 16'h0, 8'h20, 1'b0, 5'h01, `RT_ROOT, 1'b0);
      send(7'h33, 64'h0, 16'h0, 8'h19, 1'b1, 5'h1E, `RT_BCAST, 1'b0);
      send(7'h33, 64'h0, 16'h0, 8'h19, 1'b0, 5'h00, `RT_BCAST, 1'b1);
      send(7'h34, 64'h0, 16'h0, 8'h50, 1'b0, 5'h00, `RT_LOCAL, 1'b0);
      send(7'h35, 64'h0, 16'h0, 8'h1B, 1'b0, 5'h01, `RT_GATHER, 1'b0);
      send(7'h35, 64'h0, 16'h0, 8'h19, 1'b0, 5'h00, `RT_GATHER, 1'b1);
      send(7'h35, 64'h0, 16'h0, 8'h1B, 1'b1, 5'h00, `RT_GATHER, 1'b1);
      $display("test route done");
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      t_regs();
      @(posedge clk);
      link_up <= 4'hF;
      t_rotate();
      t_or();
      t_own();
      t_link();
      t_route();
      results();
   end
endmodule // tb
